//--- include/eifps_defs.svh
// register offsets, field positions, reset values and codes of the pin-switch flag block
`ifndef EIFPS_DEFS_SVH
`define EIFPS_DEFS_SVH
`define EIFPS_OFF_PFA     8'h00
`define EIFPS_OFF_PFB     8'h04
`define EIFPS_OFF_WPF     8'h08
`define EIFPS_OFF_EXTSEL  8'h0c
`define EIFPS_OFF_EVSEL   8'h10
`define EIFPS_OFF_EXTREQ  8'h14
`define EIFPS_OFF_WKREQ   8'h18
`define EIFPS_OFF_STATUS  8'h1c
`define EIFPS_OFF_CLEAR   8'h20
`define EIFPS_OFF_ENABLE  8'h24
`define EIFPS_B_INT4      4
`define EIFPS_B_INT3      3
`define EIFPS_B_EVENT     2
`define EIFPS_B_INT1      1
`define EIFPS_B_INT0      0
`define EIFPS_B_EV_LO     0
`define EIFPS_B_EV_HI     1
`define EIFPS_B_EV_SRC    2
`define EIFPS_EXT_MASK    5'h1b
`define EIFPS_RST_BYTE    8'h00
`define EIFPS_RST_HALF    16'h0000
`define EIFPS_RESP_OKAY   2'h0
`define EIFPS_RESP_SLVERR 2'h2
`endif

//--- include/eifps_pkg.sv
// types shared by the pin-switch flag block
package eifps_pkg;
   typedef logic [7:0]  eifps_byte_t;
   typedef logic [15:0] eifps_half_t;
   typedef enum logic [1:0] {
      EIFPS_EV_FALL,
      EIFPS_EV_RISE,
      EIFPS_EV_BOTH,
      EIFPS_EV_BOTH2
   } eifps_edge_t;
endpackage

//--- verif/eifps_stack_mem.sv
// stack memory model standing on the cpu side of the block
`timescale 1ns/1ps
`default_nettype none
module eifps_stack_mem (
   // clock
   input  wire logic        aclk,
   // stack bus from the block
   input  wire logic [15:0] stk_addr,
   input  wire logic [15:0] stk_wdata,
   input  wire logic        stk_we,
   input  wire logic        stk_re,
   output logic      [15:0] stk_rdata
);
   logic [15:0] mem [0:255];
   logic [15:0] held;
   logic        hold_q;
   // each word holds its index in the even byte, its inverse in the odd
   initial begin
      for (int k = 0; k < 256; k++) begin
         mem[k] = {k[7:0], ~k[7:0]};
      end
      held = 16'h0000;
      hold_q = 1'b0;
   end
   // word writes and capture of the word being read
   always @(posedge aclk) begin
      hold_q <= stk_re;
      if (stk_re) begin
         held <= mem[stk_addr[8:1]];
      end
      if (stk_we) begin
         mem[stk_addr[8:1]] <= stk_wdata;
      end
   end
   // data good in the read cycle and the next, scrambled otherwise
   assign stk_rdata = stk_re ? mem[stk_addr[8:1]] :
                      (hold_q ? held : ~held);
endmodule
`default_nettype wire

//--- verif/test_ext_int_flag_pin_switch.sv
// self-checking bench of the pin-switch request flag block
`include "eifps_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ext_int_flag_pin_switch;
   import eifps_pkg::*;
   typedef struct {
      logic [7:0]  addr;
      logic        wr;
      logic [31:0] wdata;
      logic [1:0]  bresp;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } eifps_row_t;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq, ccr_load;
   logic        event_counter_int_pin, event_counter_pwm_out;
   logic        stk_push, stk_pop, stk_we, stk_re;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, wakeup_pins, pa, pm;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [4:0]  xp;
   eifps_half_t stack_pointer, stk_addr, stk_wdata, stk_rdata;
   eifps_byte_t condition_code_reg, ccr_restore;
   int          fails, cmp_count, i;
   int          cyc = 0;
   int          pins [4] = '{4, 3, 1, 0};
   eifps_row_t  rows [13];

   // block under test and the stack memory beside it
   eifps_flags dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_int_pin_4(xp[4]),
      .ext_int_pin_3(xp[3]), .ext_int_pin_1(xp[1]), .ext_int_pin_0(xp[0]),
      .wakeup_pins, .event_counter_int_pin, .event_counter_pwm_out,
      .stk_push, .stk_pop, .stack_pointer, .condition_code_reg,
      .stk_rdata, .stk_addr, .stk_wdata, .stk_we, .stk_re, .ccr_restore,
      .ccr_load, .irq);
   eifps_stack_mem mem_u (.aclk, .stk_addr, .stk_wdata, .stk_we, .stk_re,
      .stk_rdata);

   task automatic complete_run();
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ticks(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // one write: address and data offered together, each dropped when taken
   // the wait ends on the answer only; the hang guard bounds it
   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   // let a pin change cross the synchronisers, then read the flags
   task automatic flag(input logic [7:0] a, input logic [31:0] e);
      ticks(8);
      rd(a);
      chk(d, e);
   endtask

   // one push or pop, checked on the stack bus
   task automatic stk(input logic psh, input eifps_half_t spv,
                      input eifps_byte_t cv);
      int n;
      n = 0;
      @(posedge aclk);
      stack_pointer <= spv;
      condition_code_reg <= cv;
      stk_push <= psh;
      stk_pop <= !psh;
      @(posedge aclk);
      stk_push <= 1'b0;
      stk_pop <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(stk_we || stk_re) && n < 6);
      chk(stk_addr, {spv[15:1], 1'b0});
      if (psh) chk(stk_wdata, {cv, cv});
      n = 0;
      while (!psh && !ccr_load && n < 8) begin
         @(posedge aclk);
         n++;
      end
   endtask

   // free-running clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end

   // main sequence
   initial begin
      fails = 0;
      cmp_count = 0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, stk_push, stk_pop} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      xp = 5'h1f;
      wakeup_pins = 8'hff;
      event_counter_int_pin = 1'b1;
      event_counter_pwm_out = 1'b1;
      stack_pointer = 16'h0000;
      condition_code_reg = 8'h00;
      rows = '{
         '{`EIFPS_OFF_EXTSEL, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_EVSEL, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_EXTREQ, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_WKREQ, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_ENABLE, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_EXTSEL, 1'b1, 32'h1b, 2'h0, 32'h1b, 2'h0},
         '{`EIFPS_OFF_PFB, 1'b1, 32'h0b, 2'h0, 32'h0b, 2'h0},
         '{`EIFPS_OFF_PFB, 1'b1, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_EXTSEL, 1'b1, 32'h0, 2'h0, 32'h0, 2'h0},
         '{`EIFPS_OFF_EXTREQ, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
         '{8'h28, 1'b1, 32'hff, 2'h2, 32'h0, 2'h2},
         '{`EIFPS_OFF_STATUS, 1'b1, 32'hff, 2'h2, 32'h0, 2'h0},
         '{`EIFPS_OFF_ENABLE, 1'b1, 32'hffff, 2'h0, 32'hffff, 2'h0}};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      ticks(2);
      foreach (rows[k]) begin
         if (rows[k].wr) begin
            wr(rows[k].addr, rows[k].wdata);
            chk(r, rows[k].bresp);
         end
         rd(rows[k].addr);
         chk(d, rows[k].rdata);
         chk(r, rows[k].rresp);
      end
      // interrupt pins: switch in with falling, switch out with rising
      foreach (pins[k]) begin
         i = pins[k];
         pa = (i == 4) ? `EIFPS_OFF_PFA : `EIFPS_OFF_PFB;
         pm = 8'h01 << i;
         @(posedge aclk);
         xp[i] <= 1'b0;
         wr(pa, pm);
         wr(`EIFPS_OFF_EXTREQ, 32'h0);
         flag(`EIFPS_OFF_EXTREQ, pm);
         chk(irq, 1'b1);
         wr(`EIFPS_OFF_EXTSEL, pm);
         wr(`EIFPS_OFF_EXTREQ, 32'h0);
         flag(`EIFPS_OFF_EXTREQ, 32'h0);
         wr(pa, 32'h0);
         flag(`EIFPS_OFF_EXTREQ, pm);
         wr(`EIFPS_OFF_EXTSEL, 32'h0);
         wr(`EIFPS_OFF_EXTREQ, 32'h0);
         xp[i] <= 1'b1;
         flag(`EIFPS_OFF_EXTREQ, 32'h0);
      end
      // wakeup pins, each switched in while held low
      for (int j = 0; j < 8; j++) begin
         @(posedge aclk);
         wakeup_pins[j] <= 1'b0;
         wr(`EIFPS_OFF_WPF, 32'h1 << j);
         flag(`EIFPS_OFF_WKREQ, 32'h1 << j);
         rd(`EIFPS_OFF_STATUS);
         chk(d, 32'h100 << j);
         wr(`EIFPS_OFF_WPF, 32'h0);
         wr(`EIFPS_OFF_ENABLE, 32'hffff);
         wr(`EIFPS_OFF_WKREQ, 32'h0);
         wakeup_pins[j] <= 1'b1;
         flag(`EIFPS_OFF_WKREQ, 32'h0);
      end
      // event source switch: falling ignored under rising select, then rising
      @(posedge aclk);
      event_counter_int_pin <= 1'b0;
      wr(`EIFPS_OFF_EVSEL, 32'h01);
      wr(`EIFPS_OFF_EVSEL, 32'h05);
      flag(`EIFPS_OFF_EXTREQ, 32'h0);
      wr(`EIFPS_OFF_EVSEL, 32'h01);
      flag(`EIFPS_OFF_EXTREQ, 32'h04);
      // two more flags, then partial byte clears, masking and clearing
      @(posedge aclk);
      xp[1:0] <= 2'b00;
      wr(`EIFPS_OFF_ENABLE, 32'h0);
      wr(`EIFPS_OFF_PFB, 32'h03);
      ticks(4);
      chk(irq, 1'b0);
      wr(`EIFPS_OFF_EXTREQ, 32'hff);
      wr(`EIFPS_OFF_EXTREQ, 32'hfd);
      flag(`EIFPS_OFF_EXTREQ, 32'h05);
      wr(`EIFPS_OFF_EXTREQ, 32'hff);
      flag(`EIFPS_OFF_EXTREQ, 32'h05);
      wr(`EIFPS_OFF_ENABLE, 32'h0001);
      ticks(4);
      chk(irq, 1'b1);
      wr(`EIFPS_OFF_CLEAR, 32'h0001);
      flag(`EIFPS_OFF_STATUS, 32'h04);
      chk(irq, 1'b0);
      // stacking: odd pointer, full word out, even byte back
      stk(1'b1, 16'h0101, 8'ha5);
      stk(1'b0, 16'h0101, 8'h00);
      chk(ccr_restore, 8'ha5);
      stk(1'b0, 16'h0042, 8'h00);
      chk(ccr_restore, 8'h21);
      // second reset mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      ticks(3);
      aresetn <= 1'b1;
      ticks(2);
      flag(`EIFPS_OFF_EXTSEL, 32'h0);
      flag(`EIFPS_OFF_EXTREQ, 32'h0);
      chk(irq, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire

//--- verilog/eifps_flags.sv
// external interrupt request flags with pin-function switch side effects
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`include "eifps_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - word accesses force address bit zero low
// - every stack access is word sized
// - condition codes pushed as full word
// - restore takes even byte, odd dropped
// - pin 4 switch sets flag per edge
// - pins 3,1,0 switch sets flags likewise
// - wakeup switch while pin low sets flag
// - event source change sets flag on edge
// - clear right after switch write ignored
// - zero written in byte clears set flag
// - external input 1 flag is bit one
// - edge select 0 falling, 1 rising, reset 0
module eifps_flags (
   // clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // axi4-lite write channels
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read channels
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // interrupt pins and internal event source
   input  wire logic                 ext_int_pin_4,
   input  wire logic                 ext_int_pin_3,
   input  wire logic                 ext_int_pin_1,
   input  wire logic                 ext_int_pin_0,
   input  wire logic [7:0]           wakeup_pins,
   input  wire logic                 event_counter_int_pin,
   input  wire logic                 event_counter_pwm_out,
   // condition code stacking
   input  wire logic                 stk_push,
   input  wire logic                 stk_pop,
   input  wire eifps_pkg::eifps_half_t stack_pointer,
   input  wire eifps_pkg::eifps_byte_t condition_code_reg,
   input  wire eifps_pkg::eifps_half_t stk_rdata,
   output eifps_pkg::eifps_half_t    stk_addr,
   output eifps_pkg::eifps_half_t    stk_wdata,
   output logic                      stk_we,
   output logic                      stk_re,
   output eifps_pkg::eifps_byte_t    ccr_restore,
   output logic                      ccr_load,
   // interrupt output
   output logic                      irq
);
   import eifps_pkg::*;

   // bus state
   logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic [7:0]  waddr_reg, waddr_next;
   logic [7:0]  wdat_reg, wdat_next;
   logic [15:0] wdat16_reg, wdat16_next;
   logic        wlane_reg, wlane_next;
   logic        awready_reg, awready_next, wready_reg, wready_next;
   logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wr_fire, wr_hit;
   // control and flag state
   eifps_byte_t pfa_reg, pfa_next, pfb_reg, pfb_next, wpf_reg, wpf_next;
   eifps_byte_t esel_reg, esel_next, evsel_reg, evsel_next;
   eifps_byte_t ext_flags_reg, ext_flags_next, wk_flags_reg, wk_flags_next;
   eifps_half_t en_reg, en_next;
   logic        guard_reg, guard_next, prime_reg, irq_reg, irq_next;
   logic [4:0]  ext_eff, ext_prev_reg, ext_set;
   logic [7:0]  wk_eff, wk_prev_reg, wk_set;
   logic        ev_src, ev_prev_reg, ev_set;
   eifps_edge_t ev_mode;
   logic [12:0] sync_a_reg, sync_b_reg;
   eifps_byte_t ext_keep, wk_keep;
   // stack state
   eifps_half_t stk_addr_reg, stk_addr_next, stk_wdata_reg, stk_wdata_next;
   logic        stk_we_reg, stk_we_next, stk_re_reg, stk_re_next;
   logic        pop_pend_reg, pop_pend_next, ccr_load_reg, ccr_load_next;
   eifps_byte_t ccr_reg, ccr_next;

   // pins cross into the clock domain through two flops
   always_ff @(posedge aclk) begin
      sync_a_reg <= {event_counter_int_pin, wakeup_pins, ext_int_pin_4,
                     ext_int_pin_3, ext_int_pin_1, ext_int_pin_0};
      sync_b_reg <= sync_a_reg;
   end

   // axi write and read channel control
   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      waddr_next   = waddr_reg;
      wdat_next    = wdat_reg;
      wdat16_next  = wdat16_reg;
      wlane_next   = wlane_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_have_next = 1'b1;
         waddr_next   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_have_next = 1'b1;
         wdat_next   = s_axi_wdata[7:0];
         wdat16_next = s_axi_wdata[15:0];
         wlane_next  = s_axi_wstrb[0];
      end
      wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
      wr_hit  = waddr_reg[1:0] == 2'h0 && waddr_reg <= `EIFPS_OFF_ENABLE
                && waddr_reg != `EIFPS_OFF_STATUS;
      if (wr_fire) begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? `EIFPS_RESP_OKAY : `EIFPS_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end else if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = `EIFPS_RESP_OKAY;
         case (s_axi_araddr)
            `EIFPS_OFF_PFA:    rdata_next = {24'h0, pfa_reg};
            `EIFPS_OFF_PFB:    rdata_next = {24'h0, pfb_reg};
            `EIFPS_OFF_WPF:    rdata_next = {24'h0, wpf_reg};
            `EIFPS_OFF_EXTSEL: rdata_next = {24'h0, esel_reg};
            `EIFPS_OFF_EVSEL:  rdata_next = {24'h0, evsel_reg};
            `EIFPS_OFF_EXTREQ: rdata_next = {24'h0, ext_flags_reg};
            `EIFPS_OFF_WKREQ:  rdata_next = {24'h0, wk_flags_reg};
            `EIFPS_OFF_STATUS: rdata_next = {16'h0, wk_flags_reg,
                                             ext_flags_reg};
            `EIFPS_OFF_CLEAR:  rdata_next = 32'h0;
            `EIFPS_OFF_ENABLE: rdata_next = {16'h0, en_reg};
            default: begin
               rdata_next = 32'h0;
               rresp_next = `EIFPS_RESP_SLVERR;
            end
         endcase
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next  = !w_have_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   // edge detection on the function-gated pin levels
   always_comb begin
      // a pin in port function reads as high to the detector
      ext_eff = ~{pfa_reg[4], pfb_reg[3], 1'b0, pfb_reg[1], pfb_reg[0]}
                | {sync_b_reg[3:2], 1'b1, sync_b_reg[1:0]};
      wk_eff  = ~wpf_reg | sync_b_reg[11:4];
      for (int i = 0; i < 5; i++) begin
         ext_set[i] = esel_reg[i] ? (!ext_prev_reg[i] && ext_eff[i])
                                  : (ext_prev_reg[i] && !ext_eff[i]);
      end
      ext_set = ext_set & `EIFPS_EXT_MASK & {5{prime_reg}};
      wk_set  = wk_prev_reg & ~wk_eff & {8{prime_reg}};
      ev_src  = evsel_reg[`EIFPS_B_EV_SRC] ? sync_b_reg[12]
                                           : event_counter_pwm_out;
      ev_mode = eifps_edge_t'({evsel_reg[`EIFPS_B_EV_HI],
                               evsel_reg[`EIFPS_B_EV_LO]});
      case (ev_mode)
         EIFPS_EV_FALL: ev_set = ev_prev_reg && !ev_src;
         EIFPS_EV_RISE: ev_set = !ev_prev_reg && ev_src;
         default:       ev_set = ev_prev_reg != ev_src;
      endcase
      ev_set = ev_set && prime_reg;
   end

   // register writes, flag clearing and the post-switch guard
   always_comb begin
      pfa_next   = pfa_reg;
      pfb_next   = pfb_reg;
      wpf_next   = wpf_reg;
      esel_next  = esel_reg;
      evsel_next = evsel_reg;
      en_next    = en_reg;
      guard_next = guard_reg;
      ext_keep   = 8'hff;
      wk_keep    = 8'hff;
      if (wr_fire && wlane_reg) begin
         guard_next = 1'b0;
         case (waddr_reg)
            `EIFPS_OFF_PFA:    pfa_next   = wdat_reg;
            `EIFPS_OFF_PFB:    pfb_next   = wdat_reg;
            `EIFPS_OFF_WPF:    wpf_next   = wdat_reg;
            `EIFPS_OFF_EXTSEL: esel_next  = wdat_reg;
            `EIFPS_OFF_EVSEL:  evsel_next = wdat_reg;
            `EIFPS_OFF_ENABLE: en_next    = wdat16_reg;
            `EIFPS_OFF_EXTREQ: ext_keep   = guard_reg ? 8'hff : wdat_reg;
            `EIFPS_OFF_WKREQ:  wk_keep    = guard_reg ? 8'hff : wdat_reg;
            `EIFPS_OFF_CLEAR: begin
               ext_keep = guard_reg ? 8'hff : ~wdat16_reg[7:0];
               wk_keep  = guard_reg ? 8'hff : ~wdat16_reg[15:8];
            end
            default: ext_keep = 8'hff;
         endcase
         // a switch write arms the guard for the very next write
         if (waddr_reg == `EIFPS_OFF_PFA || waddr_reg == `EIFPS_OFF_PFB ||
             waddr_reg == `EIFPS_OFF_WPF || waddr_reg == `EIFPS_OFF_EVSEL)
            guard_next = 1'b1;
      end
      // a set in the clearing cycle wins; bit 1 is input 1
      ext_flags_next = (ext_flags_reg & ext_keep)
                       | {3'h0, ext_set[4:3], ev_set, ext_set[1:0]};
      wk_flags_next  = (wk_flags_reg & wk_keep) | wk_set;
      irq_next = |({wk_flags_next, ext_flags_next} & en_next);
   end

   // condition code stacking, always word wide and even aligned
   always_comb begin
      stk_addr_next  = stk_addr_reg;
      stk_wdata_next = stk_wdata_reg;
      stk_we_next    = 1'b0;
      stk_re_next    = 1'b0;
      pop_pend_next  = stk_re_reg;
      ccr_next       = ccr_reg;
      ccr_load_next  = 1'b0;
      if (stk_push || stk_pop) begin
         stk_addr_next = {stack_pointer[15:1], 1'b0};
         stk_we_next   = stk_push;
         stk_re_next   = !stk_push && stk_pop;
      end
      if (stk_push)
         stk_wdata_next = {condition_code_reg, condition_code_reg};
      if (pop_pend_reg) begin
         ccr_next      = stk_rdata[15:8];
         ccr_load_next = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         waddr_reg     <= `EIFPS_RST_BYTE;
         wdat_reg      <= `EIFPS_RST_BYTE;
         wdat16_reg    <= `EIFPS_RST_HALF;
         wlane_reg     <= 1'b0;
         awready_reg   <= 1'b0;
         wready_reg    <= 1'b0;
         arready_reg   <= 1'b0;
         bvalid_reg    <= 1'b0;
         rvalid_reg    <= 1'b0;
         bresp_reg     <= `EIFPS_RESP_OKAY;
         rresp_reg     <= `EIFPS_RESP_OKAY;
         rdata_reg     <= 32'h0;
         pfa_reg       <= `EIFPS_RST_BYTE;
         pfb_reg       <= `EIFPS_RST_BYTE;
         wpf_reg       <= `EIFPS_RST_BYTE;
         esel_reg      <= `EIFPS_RST_BYTE;
         evsel_reg     <= `EIFPS_RST_BYTE;
         en_reg        <= `EIFPS_RST_HALF;
         ext_flags_reg <= `EIFPS_RST_BYTE;
         wk_flags_reg  <= `EIFPS_RST_BYTE;
         guard_reg     <= 1'b0;
         prime_reg     <= 1'b0;
         irq_reg       <= 1'b0;
         ext_prev_reg  <= 5'h1f;
         wk_prev_reg   <= 8'hff;
         ev_prev_reg   <= 1'b1;
         stk_addr_reg  <= `EIFPS_RST_HALF;
         stk_wdata_reg <= `EIFPS_RST_HALF;
         stk_we_reg    <= 1'b0;
         stk_re_reg    <= 1'b0;
         pop_pend_reg  <= 1'b0;
         ccr_reg       <= `EIFPS_RST_BYTE;
         ccr_load_reg  <= 1'b0;
      end else begin
         aw_have_reg   <= aw_have_next;
         w_have_reg    <= w_have_next;
         waddr_reg     <= waddr_next;
         wdat_reg      <= wdat_next;
         wdat16_reg    <= wdat16_next;
         wlane_reg     <= wlane_next;
         awready_reg   <= awready_next;
         wready_reg    <= wready_next;
         arready_reg   <= arready_next;
         bvalid_reg    <= bvalid_next;
         rvalid_reg    <= rvalid_next;
         bresp_reg     <= bresp_next;
         rresp_reg     <= rresp_next;
         rdata_reg     <= rdata_next;
         pfa_reg       <= pfa_next;
         pfb_reg       <= pfb_next;
         wpf_reg       <= wpf_next;
         esel_reg      <= esel_next;
         evsel_reg     <= evsel_next;
         en_reg        <= en_next;
         ext_flags_reg <= ext_flags_next;
         wk_flags_reg  <= wk_flags_next;
         guard_reg     <= guard_next;
         prime_reg     <= 1'b1;
         irq_reg       <= irq_next;
         ext_prev_reg  <= ext_eff;
         wk_prev_reg   <= wk_eff;
         ev_prev_reg   <= ev_src;
         stk_addr_reg  <= stk_addr_next;
         stk_wdata_reg <= stk_wdata_next;
         stk_we_reg    <= stk_we_next;
         stk_re_reg    <= stk_re_next;
         pop_pend_reg  <= pop_pend_next;
         ccr_reg       <= ccr_next;
         ccr_load_reg  <= ccr_load_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign stk_addr      = stk_addr_reg;
   assign stk_wdata     = stk_wdata_reg;
   assign stk_we        = stk_we_reg;
   assign stk_re        = stk_re_reg;
   assign ccr_restore   = ccr_reg;
   assign ccr_load      = ccr_load_reg;
   assign irq           = irq_reg;

   // checks on the flag and stacking behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence irr_write_s(int b);
      wr_fire && wlane_reg && waddr_reg == `EIFPS_OFF_EXTREQ && !wdat_reg[b];
   endsequence
   sequence pop_s;
      stk_pop && !stk_push ##1 stk_re_reg ##1 pop_pend_reg;
   endsequence

   stack_align_a: assert property (
      (stk_we_reg || stk_re_reg) |-> !stk_addr_reg[0])
      else $error("stack access on odd address");
   ccr_push_a: assert property (
      stk_push |=> stk_we_reg && stk_wdata_reg ==
         {$past(condition_code_reg), $past(condition_code_reg)})
      else $error("condition codes not pushed as word");
   ccr_pop_a: assert property (
      pop_s |=> ccr_load_reg && ccr_reg == $past(stk_rdata[15:8]))
      else $error("restore not from even byte");
   pin4_switch_a: assert property (
      prime_reg && $rose(pfa_reg[4]) && !sync_b_reg[3] && !esel_reg[4]
      |=> ext_flags_reg[4])
      else $error("pin 4 switch did not set flag");
   pin0_switch_a: assert property (
      prime_reg && $fell(pfb_reg[0]) && !sync_b_reg[0] && esel_reg[0]
      |=> ext_flags_reg[0])
      else $error("pin 0 switch back did not set flag");
   wake_switch_a: assert property (
      prime_reg && $rose(wpf_reg[7]) && !sync_b_reg[11]
      |=> wk_flags_reg[7])
      else $error("wakeup switch did not set flag");
   event_edge_a: assert property (
      prime_reg && ev_mode == EIFPS_EV_RISE && !ev_prev_reg && ev_src
      |=> ext_flags_reg[`EIFPS_B_EVENT])
      else $error("event source edge lost");
   guard_keep_a: assert property (
      guard_reg && ext_flags_reg[1] ##0 irr_write_s(1) |=> ext_flags_reg[1])
      else $error("clear after switch took effect");
   clear_zero_a: assert property (
      !guard_reg && !ext_set[0] ##0 irr_write_s(0) |=> !ext_flags_reg[0])
      else $error("zero write did not clear flag");
   irq_level_a: assert property (
      irq_reg == |({wk_flags_reg, ext_flags_reg} & en_reg))
      else $error("interrupt output disagrees with status");
endmodule
`default_nettype wire
